// ===== pkg/mbd_cfg.svh
`ifndef MBD_CFG_SVH
`define MBD_CFG_SVH

// Bus address layout
`define MBD_BUS_AW 18
`define MBD_BIT_BYTE 0
`define MBD_BIT_A01 1
`define MBD_WA_LO 2
`define MBD_WA_HI 12
`define MBD_BIT_A13 13
`define MBD_SEL_LO 13
`define MBD_SEL_HI 17
`define MBD_SEL_W 5
`define MBD_BUS_IDLE 18'h3ffff
`define MBD_PIN_IDLE 1'b1

// Line decoder fields on the bus address
`define MBD_BIT_A02 2
`define MBD_BIT_A03 3
`define MBD_YSW_LO 4
`define MBD_YSW_HI 6
`define MBD_XDRV_LO 7
`define MBD_XDRV_HI 9
`define MBD_XSW_LO 10
`define MBD_XSW_HI 12

// Word address register layout: bit k holds bus bit k+1
`define MBD_WA_W 13
`define MBD_WA_WORD_BIT1_INTERNAL 0
`define MBD_WA_A02 1
`define MBD_WA_A03 2
`define MBD_WA_YSW_LO 3
`define MBD_WA_YSW_HI 5
`define MBD_WA_XDRV_LO 6
`define MBD_WA_XDRV_HI 8
`define MBD_WA_XSW_LO 9
`define MBD_WA_XSW_HI 12
`define MBD_WA_A13 12

// Register offsets (byte addresses)
`define MBD_REG_AW 8
`define MBD_OFF_CTRL 8'h00
`define MBD_OFF_STATUS 8'h04
`define MBD_OFF_COUNT 8'h08
`define MBD_OFF_CONFIG 8'h0c

// Field positions and reset values
`define MBD_CTRL_DEC_EN 0
`define MBD_CTRL_CNT_CLR 1
`define MBD_CTRL_RST 1'h1
`define MBD_ST_SEL 0
`define MBD_ST_SIZE 1
`define MBD_ST_PWR 2
`define MBD_ST_WA_LO 8
`define MBD_CFG_BASE_LO 0
`define MBD_CFG_SIZE 8
`define MBD_CNT_W 16

// AXI responses
`define MBD_RESP_OKAY 2'h0
`define MBD_RESP_SLVERR 2'h2

`endif

// ===== pkg/mbd_pkg.sv
`default_nettype none
package mbd_pkg;

   // AXI4-Lite master to slave
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } mbd_axi_req_t;

   // AXI4-Lite slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mbd_axi_rsp_t;

   // Line selections toward the switch and driver stages
   typedef struct packed {
      logic [7:0] y_drv;
      logic [7:0] y_sw;
      logic [7:0] x_drv;
      logic [15:0] x_sw;
   } mbd_lines_t;

   // State of the top module
   typedef struct packed {
      logic [17:0] addr_s1;
      logic [17:0] addr_s2;
      logic pwr_s1;
      logic pwr_s2;
      logic [12:0] word_addr;
      logic [1:0] byte_lane;
      logic bank_sel;
      logic decode_en;
      logic [15:0] sel_count;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      mbd_axi_rsp_t rsp;
   } mbd_top_state_t;

endpackage : mbd_pkg
`default_nettype wire

// ===== rtl/mbd_decoder.sv
// What this block does
// - Bits 17-13 form the bank's device-address field; bit 1 is a word-address bit.
// - Word location comes from bits 12-2, bit 1, and bit 13 when large.
// - In byte writes, bit 0 picks which byte of the word is written.
// - Latched word address decodes into Y/X driver and switch line selections.
// - Compare bits 17-13 in 4K mode, bits 17-14 only in 8K mode.
// - In 8K mode bit 13 becomes a word-address bit choosing X switches.
// - Bank select only when all compared bits and inputs match.
// - Each base bit expects zero where configured zero, else one.
// - Power-low indication is compared; selection needs it inactive.
// - In 8K mode the bit-13 compare position always matches.
// - Each bank gets a distinct base; 4K banks sit in consecutive ranges.
// - Word has low byte at even address, high at odd; words even only.
// - An 8K bank answers byte offsets 000000 to 037777 octal.
// - Bus lines are active low; internal logic is active high.
// - 8K bank is non-interleaved only; no interleaved mapping exists.
// - Received bit 1 passes to the word register in both sizes.
// - Word address register loads on the control logic's latch edge.
`timescale 1ns/1ps
`default_nettype none
`include "mbd_cfg.svh"
module mbd_decoder #(
   // Static size strap
   // Bank size: 0 selects 4K words, 1 selects 8K words
   parameter bit SIZE_8K = 1'b0,
   // Distinct base per bank
   // Expected logical values of address bits 17..13
   parameter logic [4:0] BASE_HI = 5'h00
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Bus pins, active low
   input wire logic [17:0] bus_addr_n,
   input wire logic bus_pwr_low_n,
   // Control logic, same clock domain
   input wire logic addr_latch,
   input wire logic byte_write,
   // Register bus
   input wire mbd_pkg::mbd_axi_req_t axi_req,
   output mbd_pkg::mbd_axi_rsp_t axi_rsp,
   // Decode results
   output logic bank_sel,
   output logic [12:0] word_addr,
   output logic [1:0] byte_lane,
   output mbd_pkg::mbd_lines_t lines
);

   mbd_pkg::mbd_top_state_t st_q;
   mbd_pkg::mbd_top_state_t st_d;

   logic [17:0] addr_pos;
   logic pwr_low;
   logic sel_now;
   logic dec_load;
   logic wr_fire;
   logic rd_fire;

   // Per-bit compare
   // Match of one compared bit against its expected value, with 8K forcing bit 13 to match
   function automatic logic field_match(input logic got, input logic want, input logic forced);
      field_match = forced | (got == want);
   endfunction : field_match

   // Device field compare
   // Full bank compare over the device-address field and power-low; bits below stay free
   function automatic logic bank_match(input logic [17:0] a, input logic low);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < `MBD_SEL_W; i++) begin
         ok = ok & field_match(a[`MBD_SEL_LO + i], BASE_HI[i], SIZE_8K && (i == 0));
      end
      bank_match = ok & ~low;
   endfunction : bank_match

   // Even low, odd high
   // Byte lanes: word write takes both, byte write takes the one bit 0 names
   function automatic logic [1:0] lanes_of(input logic byte_op, input logic a0);
      if (!byte_op) begin
         lanes_of = 2'h3;
      end else if (a0) begin
         lanes_of = 2'h2;
      end else begin
         lanes_of = 2'h1;
      end
   endfunction : lanes_of

   // Register read mux
   function automatic logic [31:0] reg_read(input logic [7:0] addr, input mbd_pkg::mbd_top_state_t s);
      logic [31:0] v;
      v = 32'h0;
      case (addr)
         `MBD_OFF_CTRL: begin
            v[`MBD_CTRL_DEC_EN] = s.decode_en;
         end
         `MBD_OFF_STATUS: begin
            v[`MBD_ST_SEL] = s.bank_sel;
            v[`MBD_ST_SIZE] = SIZE_8K;
            v[`MBD_ST_PWR] = s.pwr_s2;
            v[`MBD_ST_WA_LO +: `MBD_WA_W] = s.word_addr;
         end
         `MBD_OFF_COUNT: begin
            v[`MBD_CNT_W-1:0] = s.sel_count;
         end
         `MBD_OFF_CONFIG: begin
            v[`MBD_CFG_BASE_LO +: `MBD_SEL_W] = BASE_HI;
            v[`MBD_CFG_SIZE] = SIZE_8K;
         end
         default: begin
            v = 32'h0;
         end
      endcase
      reg_read = v;
   endfunction : reg_read

   function automatic logic reg_mapped(input logic [7:0] addr);
      case (addr)
         `MBD_OFF_CTRL, `MBD_OFF_STATUS, `MBD_OFF_COUNT, `MBD_OFF_CONFIG: begin
            reg_mapped = 1'b1;
         end
         default: begin
            reg_mapped = 1'b0;
         end
      endcase
   endfunction : reg_mapped

   assign addr_pos = ~st_q.addr_s2;
   assign pwr_low = ~st_q.pwr_s2;
   assign sel_now = bank_match(addr_pos, pwr_low);
   assign dec_load = addr_latch;
   assign wr_fire = st_q.aw_got & st_q.w_got & ~st_q.rsp.bvalid;
   assign rd_fire = axi_req.arvalid & st_q.rsp.arready;

   always_comb begin
      st_d = st_q;

      // Pins cross two flops before any logic reads them
      st_d.addr_s1 = bus_addr_n;
      st_d.addr_s2 = st_q.addr_s1;
      st_d.pwr_s1 = bus_pwr_low_n;
      st_d.pwr_s2 = st_q.pwr_s1;

      // Bank select follows the live compare
      st_d.bank_sel = sel_now;

      if (dec_load) begin
         // Bit 1 kept in both sizes
         st_d.word_addr[`MBD_WA_WORD_BIT1_INTERNAL] = addr_pos[`MBD_BIT_A01];
         st_d.word_addr[`MBD_WA_A13-1:`MBD_WA_A02] = addr_pos[`MBD_WA_HI:`MBD_WA_LO];
         // Bit 13 is a word bit only in 8K mode
         st_d.word_addr[`MBD_WA_A13] = SIZE_8K ? addr_pos[`MBD_BIT_A13] : 1'b0;
         st_d.byte_lane = lanes_of(byte_write, addr_pos[`MBD_BIT_BYTE]);
         // Count selections so software sees traffic reaching this bank
         if (sel_now && st_q.decode_en) begin
            st_d.sel_count = st_q.sel_count + 16'h1;
         end
      end

      // Write address and data are taken in either order
      if (axi_req.awvalid && st_q.rsp.awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && st_q.rsp.wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = axi_req.wdata;
         st_d.wstrb = axi_req.wstrb;
      end

      // Write commits once both halves are held
      if (wr_fire) begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.rsp.bvalid = 1'b1;
         st_d.rsp.bresp = reg_mapped(st_q.awaddr) ? `MBD_RESP_OKAY : `MBD_RESP_SLVERR;
         if (st_q.awaddr == `MBD_OFF_CTRL && st_q.wstrb[0]) begin
            st_d.decode_en = st_q.wdata[`MBD_CTRL_DEC_EN];
            // Clear loses to a selection counted in the same cycle
            if (st_q.wdata[`MBD_CTRL_CNT_CLR] && !(dec_load && sel_now && st_q.decode_en)) begin
               st_d.sel_count = 16'h0;
            end
         end
      end
      if (st_q.rsp.bvalid && axi_req.bready) begin
         st_d.rsp.bvalid = 1'b0;
      end

      // Ready stays low while a half is held or a response waits
      st_d.rsp.awready = ~st_d.aw_got & ~st_d.rsp.bvalid & ~wr_fire;
      st_d.rsp.wready = ~st_d.w_got & ~st_d.rsp.bvalid & ~wr_fire;

      // Reads answer one cycle after the address is taken
      if (rd_fire) begin
         st_d.rsp.rvalid = 1'b1;
         st_d.rsp.rdata = reg_read(axi_req.araddr, st_q);
         st_d.rsp.rresp = reg_mapped(axi_req.araddr) ? `MBD_RESP_OKAY : `MBD_RESP_SLVERR;
      end
      if (st_q.rsp.rvalid && axi_req.rready) begin
         st_d.rsp.rvalid = 1'b0;
      end
      st_d.rsp.arready = ~st_d.rsp.rvalid & ~rd_fire;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         // Idle bus lines rest high
         st_q.addr_s1 <= `MBD_BUS_IDLE;
         st_q.addr_s2 <= `MBD_BUS_IDLE;
         st_q.pwr_s1 <= `MBD_PIN_IDLE;
         st_q.pwr_s2 <= `MBD_PIN_IDLE;
         st_q.decode_en <= `MBD_CTRL_RST;
         st_q.byte_lane <= 2'h0;
         st_q.rsp.awready <= 1'b1;
         st_q.rsp.wready <= 1'b1;
         st_q.rsp.arready <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Line decoders; lines load on the latch pulse and drive a line only when this bank is chosen
   logic line_en;
   logic [2:0] ydrv_code;
   logic [3:0] xsw_code;

   assign line_en = st_q.decode_en & sel_now;
   assign ydrv_code = {addr_pos[`MBD_BIT_A01], addr_pos[`MBD_BIT_A03], addr_pos[`MBD_BIT_A02]};
   assign xsw_code = {SIZE_8K ? addr_pos[`MBD_BIT_A13] : 1'b0, addr_pos[`MBD_XSW_HI:`MBD_XSW_LO]};

   mbd_line_dec #(
      .IN_W(3)
   ) u_y_drv (
      .clock(clock),
      .rst_n(rst_n),
      .load(dec_load),
      .enable(line_en),
      .code(ydrv_code),
      .sel(lines.y_drv)
   );

   mbd_line_dec #(
      .IN_W(3)
   ) u_y_sw (
      .clock(clock),
      .rst_n(rst_n),
      .load(dec_load),
      .enable(line_en),
      .code(addr_pos[`MBD_YSW_HI:`MBD_YSW_LO]),
      .sel(lines.y_sw)
   );

   mbd_line_dec #(
      .IN_W(3)
   ) u_x_drv (
      .clock(clock),
      .rst_n(rst_n),
      .load(dec_load),
      .enable(line_en),
      .code(addr_pos[`MBD_XDRV_HI:`MBD_XDRV_LO]),
      .sel(lines.x_drv)
   );

   // Bit 13 extends the X switch choice in 8K mode
   mbd_line_dec #(
      .IN_W(4)
   ) u_x_sw (
      .clock(clock),
      .rst_n(rst_n),
      .load(dec_load),
      .enable(line_en),
      .code(xsw_code),
      .sel(lines.x_sw)
   );

   assign axi_rsp = st_q.rsp;
   assign bank_sel = st_q.bank_sel;
   assign word_addr = st_q.word_addr;
   assign byte_lane = st_q.byte_lane;

endmodule : mbd_decoder
`default_nettype wire

// ===== rtl/mbd_line_dec.sv
`timescale 1ns/1ps
`default_nettype none
// Registered one-of-N line decoder; a load while disabled turns all lines off
module mbd_line_dec #(
   parameter int IN_W = 3
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic load,
   input wire logic enable,
   input wire logic [IN_W-1:0] code,
   // Selected line
   output logic [(1<<IN_W)-1:0] sel
);

   typedef struct packed {
      logic [(1<<IN_W)-1:0] sel;
   } mbd_dec_state_t;

   mbd_dec_state_t st_q;
   mbd_dec_state_t st_d;

   always_comb begin
      st_d = st_q;
      if (load) begin
         st_d.sel = '0;
         if (enable) begin
            st_d.sel[code] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sel = st_q.sel;

endmodule : mbd_line_dec
`default_nettype wire

// ===== verif/mbd_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mbd_decoder_asserts #(
   parameter bit SIZE_8K = 1'b0,
   parameter logic [4:0] BASE_HI = 5'h00
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Inputs
   input wire logic [17:0] bus_addr_n,
   input wire logic bus_pwr_low_n,
   input wire logic addr_latch,
   input wire logic byte_write,
   input wire mbd_pkg::mbd_axi_req_t axi_req,
   // Outputs
   input wire mbd_pkg::mbd_axi_rsp_t axi_rsp,
   input wire logic bank_sel,
   input wire logic [12:0] word_addr,
   input wire logic [1:0] byte_lane,
   input wire mbd_pkg::mbd_lines_t lines
);
   // Select register still reflects sync-flop reset values for three edges
   logic [1:0] age_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         age_q <= 2'h0;
      end else if (age_q != 2'h3) begin
         age_q <= age_q + 2'h1;
      end
   end
   function automatic logic sel_f(input logic [17:0] pn, input logic pw);
      return pw && (~pn[17:14] == BASE_HI[4:1]) && (SIZE_8K || !pn[13] == BASE_HI[0]);
   endfunction : sel_f
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence late_latch_s;
      age_q == 2'h3 && addr_latch;
   endsequence
   sequence wr_take_s;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   sel_match_a: assert property (
      age_q == 2'h3 |-> bank_sel == sel_f($past(bus_addr_n, 3), $past(bus_pwr_low_n, 3)))
      else $error("Bank select wrong");
   word_load_a: assert property (
      late_latch_s |=> word_addr == {SIZE_8K & !$past(bus_addr_n[13], 3), ~$past(bus_addr_n[12:1], 3)})
      else $error("Word address wrong");
   lane_pick_a: assert property (
      late_latch_s |=> byte_lane == ($past(byte_write) ? {!$past(bus_addr_n[0], 3), $past(bus_addr_n[0], 3)} : 2'h3))
      else $error("Byte lane wrong");
   line_dec_a: assert property (
      late_latch_s |=> lines == '0 || (sel_f($past(bus_addr_n, 3), $past(bus_pwr_low_n, 3))
      && lines.x_sw == 16'h1 << {SIZE_8K & !$past(bus_addr_n[13], 3), ~$past(bus_addr_n[12:10], 3)}))
      else $error("Line select wrong");
   line_idle_a: assert property (
      late_latch_s ##0 !sel_f($past(bus_addr_n, 2), $past(bus_pwr_low_n, 2)) |=> lines == '0)
      else $error("Lines moved while unselected");
   word_hold_a: assert property (
      !addr_latch |=> $stable(word_addr) && $stable(byte_lane) && $stable(lines))
      else $error("Latched value moved");
   wr_resp_a: assert property (wr_take_s |-> ##2 axi_rsp.bvalid)
      else $error("Write response late");
   rd_resp_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("Read response late");
   map_err_a: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 8'h10
      |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0)
      else $error("Unmapped read answered");
endmodule : mbd_decoder_asserts
bind mbd_decoder mbd_decoder_asserts #(.SIZE_8K(SIZE_8K), .BASE_HI(BASE_HI)) chk_i (.clock(clock), .rst_n(rst_n),
   .bus_addr_n(bus_addr_n), .bus_pwr_low_n(bus_pwr_low_n), .addr_latch(addr_latch), .byte_write(byte_write),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .bank_sel(bank_sel), .word_addr(word_addr), .byte_lane(byte_lane),
   .lines(lines));
`default_nettype wire

// ===== verif/mbd_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side bus master: turns a logical request into pin levels
module mbd_master_model (
   // Request
   input wire logic drive,
   input wire logic [17:0] addr,
   input wire logic pwr_low,
   // Bus pins
   output logic [17:0] bus_addr_n,
   output logic bus_pwr_low_n
);
   // active low, released lines rest high
   assign bus_addr_n = drive ? ~addr : 18'h3ffff;
   assign bus_pwr_low_n = ~pwr_low;
endmodule : mbd_master_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam bit S8 = 1'b1;
   localparam logic [4:0] BH = 5'h16;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic drive = 1'b0;
   logic pwr_low = 1'b0;
   logic addr_latch = 1'b0;
   logic byte_write = 1'b0;
   logic [17:0] addr = 18'h0;
   logic [17:0] bus_addr_n;
   logic bus_pwr_low_n;
   logic bank_sel;
   logic [12:0] word_addr;
   logic [1:0] byte_lane;
   logic [31:0] rd;
   logic [31:0] rnd;
   logic [1:0] rr;
   mbd_pkg::mbd_axi_req_t req = '0;
   mbd_pkg::mbd_axi_rsp_t rsp;
   mbd_pkg::mbd_lines_t lines;
   int bad_count = 0;
   int num_checks = 0;
   int hits = 0;
   always #5 clock = ~clock;
   mbd_master_model mbd_master_model_i (.drive(drive), .addr(addr), .pwr_low(pwr_low), .bus_addr_n(bus_addr_n),
      .bus_pwr_low_n(bus_pwr_low_n));
   mbd_decoder #(.SIZE_8K(S8), .BASE_HI(BH)) mbd_decoder_i (.clock(clock), .rst_n(rst_n), .bus_addr_n(bus_addr_n),
      .bus_pwr_low_n(bus_pwr_low_n), .addr_latch(addr_latch), .byte_write(byte_write), .axi_req(req),
      .axi_rsp(rsp), .bank_sel(bank_sel), .word_addr(word_addr), .byte_lane(byte_lane), .lines(lines));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic tick(inout int n);
      @(posedge clock);
      n++;
      if (n > 40) begin
         bad_count++;
         $display("[FAIL] %0t bus timeout", $time);
         complete_run();
      end
   endtask : tick
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      req.awvalid <= 1'b1;
      req.awaddr <= ad;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      do begin
         tick(n);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      req.bready <= 1'b0;
      check(rsp.bresp, er);
      @(posedge clock);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] ad);
      int n;
      n = 0;
      req.arvalid <= 1'b1;
      req.araddr <= ad;
      req.rready <= 1'b1;
      do begin
         tick(n);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      rd = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
      @(posedge clock);
   endtask : axi_rd
   function automatic logic exp_sel(input logic [17:0] a, input logic pl);
      return !pl && a[17:14] == BH[4:1] && (S8 || a[13] == BH[0]);
   endfunction : exp_sel
   function automatic mbd_pkg::mbd_lines_t exp_ln(input logic [17:0] a);
      return {8'h01 << {a[1], a[3], a[2]}, 8'h01 << a[6:4], 8'h01 << a[9:7], 16'h1 << {S8 & a[13], a[12:10]}};
   endfunction : exp_ln
   // Pins settle through two sync flops before the latch pulse
   task automatic probe(input logic [17:0] a, input logic pl, input logic bw, input logic en);
      logic s;
      s = exp_sel(a, pl);
      drive <= 1'b1;
      addr <= a;
      pwr_low <= pl;
      repeat (4) @(posedge clock);
      check(bank_sel, s);
      addr_latch <= 1'b1;
      byte_write <= bw;
      @(posedge clock);
      addr_latch <= 1'b0;
      @(posedge clock);
      check(word_addr, {S8 & a[13], a[12:1]});
      check(byte_lane, bw ? (a[0] ? 2'h2 : 2'h1) : 2'h3);
      check(lines, (s && en) ? exp_ln(a) : '0);
      if (s && en) hits++;
   endtask : probe
   initial begin
      void'($urandom(22));
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      axi_rd(8'h0c);
      check(rd, {23'h0, S8, 3'h0, BH});
      axi_rd(8'h00);
      check(rd, 32'h1);
      axi_rd(8'h10);
      check({rd, rr}, {32'h0, 2'h2});
      axi_wr(8'h10, 32'h0, 2'h2);
      axi_wr(8'h00, 32'h3, 2'h0);
      $display("registers done");
      probe({BH[4:1], 14'h0}, 1'b0, 1'b0, 1'b1);
      probe({BH[4:1], 14'h3fff}, 1'b0, 1'b1, 1'b1);
      probe({BH[4:1], 14'h2000}, 1'b1, 1'b0, 1'b1);
      probe({~BH[4:1], 14'h0}, 1'b0, 1'b1, 1'b1);
      $display("corners done");
      for (int i = 0; i < 30; i++) begin
         rnd = $urandom;
         if (i[0]) rnd[17:14] = BH[4:1];
         probe(rnd[17:0], rnd[31:29] == 3'h0, rnd[28], 1'b1);
      end
      $display("random done");
      axi_wr(8'h00, 32'h0, 2'h0);
      probe({BH[4:1], 14'h1234}, 1'b0, 1'b0, 1'b0);
      axi_rd(8'h08);
      check(rd, hits);
      axi_rd(8'h04);
      // Status shows live select, size, idle power pin and the last latched word
      check(rd, {11'h0, 1'b0, 12'h91a, 5'h0, 1'b1, S8, 1'b1});
      $display("disable done");
      complete_run();
   end
endmodule : tb
`default_nettype wire
